//--- src/lri_pkg.sv
// Shared constants and carrier types for the link reset and width initialisation block.
package lri_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int REF_CLK_MHZ = 50;           // Core clock rate in MHz.
   localparam int COLD_LINK_MHZ = 200;        // Link clock rate after a cold reset.
   localparam int MIN_RX_LINK_MHZ = 200;      // Lowest forwarded clock every receiver takes.
   localparam int CTL_DELAY_US = 1;           // Device-specific wait after reset before CTL.
   localparam int CTL_DELAY_CYC = (CTL_DELAY_US * REF_CLK_MHZ > 1) ?
                                  CTL_DELAY_US * REF_CLK_MHZ : 1;
   localparam int SYNC_HOLD_BT = 16;          // All-ones hold after both CTLs seen.
   localparam int LOW_HOLD_BT = 512;          // Low hold base length.
   localparam int LOW_STEP_BT = 4;            // Low hold extension step.
   localparam int FRAME_BT = 4;               // CAD-high framing bit-times.
   localparam int CRC_GAP_BT = 512;           // Bit-times between CRC insertions.
   localparam int CRC_SETTLE_CYC = 4;         // Core cycles before CRC flops are read.
   localparam int TX_PPM_MAX = 1000;          // Async transmit overspeed limit.
   localparam int PEER_PPM_MAX = 2000;        // Async overspeed versus receiver.

   // ----------------------------------------
   // CAD width patterns
   // ----------------------------------------
   localparam logic [31:0] CAD_PAT_W2 = 32'h0000_0003;
   localparam logic [31:0] CAD_PAT_W4 = 32'h0000_000f;
   localparam logic [31:0] CAD_PAT_W8 = 32'h0000_00ff;
   localparam logic [31:0] CAD_PAT_W16 = 32'h0000_ffff;
   localparam logic [31:0] CAD_PAT_ALL = 32'hffff_ffff;
   localparam logic [31:0] CAD_PAT_NONE = 32'h0000_0000;

   // ----------------------------------------
   // Width codes
   // ----------------------------------------
   localparam logic [2:0] WID_8 = 3'h0;
   localparam logic [2:0] WID_16 = 3'h1;
   localparam logic [2:0] WID_32 = 3'h3;
   localparam logic [2:0] WID_2 = 3'h4;
   localparam logic [2:0] WID_4 = 3'h5;
   localparam logic [2:0] WID_RST = WID_8;    // Width field reset value.

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;    // [0] go, [1] async, [3:2] low-hold extra N.
   localparam logic [3:0] REG_WIDTH = 4'h1;   // [2:0] width in, [6:4] width out, rw.
   localparam logic [3:0] REG_STATUS = 4'h2;  // [0] end of chain, [1] done, [6:4] state.
   localparam logic [3:0] REG_CRC = 4'h3;     // [31:0] last captured CRC word.
   localparam logic [3:0] REG_PTR = 4'h4;     // [7:0] read pointer, [15:8] freeze count.
   localparam logic [3:0] REG_ERRLOG = 4'h5;  // [0] persistent CRC miss flag.

   // Sync sequence states, Gray coded along the normal path.
   typedef enum logic [2:0] {
      LRI_ST_RESET = 3'b000,
      LRI_ST_WAIT = 3'b001,
      LRI_ST_SYNC = 3'b011,
      LRI_ST_LOW = 3'b010,
      LRI_ST_FRAME = 3'b110,
      LRI_ST_RUN = 3'b111
   } lri_state_t;

   // Outbound link lines travel together.
   typedef struct packed {
      logic ctl;
      logic [31:0] cad;
   } lri_link_t;

endpackage : lri_pkg

//--- src/lri_link_init.sv
// Reset sequencing, CAD width negotiation, sync sequence and receive pointer start.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps

module lri_link_init #(
   parameter int RX_WIDTH = 8,                // Receiver width in bits.
   parameter int TX_WIDTH = 8,                // Transmitter width in bits.
   parameter int PTR_W = 3,                   // Receive pointer width.
   parameter int PTR_OFFSET = 4               // Load ahead of unload after start.
) (
   // Core clock, enable and resets.
   input wire logic ref_clk_i,
   input wire logic ce_i,
   input wire logic rstn_i,
   input wire logic pwrok_i,
   // Link receive side pins.
   input wire logic rx_clk_i,
   input wire logic rx_ctl_i,
   input wire logic [31:0] rx_cad_i,
   // Link transmit side pins.
   output lri_pkg::lri_link_t tx_link_o,
   output logic tx_clk_o,
   // Register port.
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Status.
   output logic link_up_o,
   output logic rd_ptr_adv_o
);
   import lri_pkg::*;

   // ----------------------------------------
   // Reset classification
   // ----------------------------------------
   // Reset is undefined before power-good, so power-good gates it in.
   logic int_rstn;
   assign int_rstn = rstn_i & pwrok_i;
   logic cold_reg;                        // Set once a cold reset is seen.
   logic pwrok_s1_reg, pwrok_s2_reg;
   lri_state_t cur_reg;                   // Sync sequence state.
   logic crc_miss;                        // Late CRC flop check failed.

   // Power-good is only sampled once the chain is out of reset.
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         pwrok_s1_reg <= 1'b0;
         pwrok_s2_reg <= 1'b0;
      end else begin
         pwrok_s1_reg <= 1'b1;
         pwrok_s2_reg <= pwrok_s1_reg;
      end
   end

   // Cold flag: power-good low forces it high asynchronously via its own reset.
   always_ff @(posedge ref_clk_i or negedge pwrok_i) begin
      if (!pwrok_i) begin
         cold_reg <= 1'b1;
      end else if (ce_i && pwrok_s2_reg && cur_reg == LRI_ST_RUN) begin
         cold_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // No reset here: the flops keep tracking the pins through reset, so the
   // CAD pattern has settled by the time it is sampled after release.
   logic [33:0] rx_s1_reg, rx_s2_reg, rx_s3_reg;
   always_ff @(posedge ref_clk_i) begin
      if (ce_i) begin
         rx_s1_reg <= {rx_clk_i, rx_ctl_i, rx_cad_i};
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
      end
   end
   logic rx_clk_s, rx_ctl_s;
   logic [31:0] rx_cad_s;
   assign {rx_clk_s, rx_ctl_s, rx_cad_s} = rx_s2_reg;
   // Rising edge of the forwarded clock marks one received bit-time.
   logic rx_edge;
   assign rx_edge = rx_clk_s & ~rx_s3_reg[33];

   // ----------------------------------------
   // Transmit clock and bit-time tick
   // ----------------------------------------
   // A core divider stands in for the 200 MHz link clock at reset rate.
   // It is exact and stable from the first edge, so reset never needs
   // stretching and the transmit rate carries no ppm offset.
   logic tick_reg;
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         tx_clk_o <= 1'b0;
         tick_reg <= 1'b0;
      end else if (ce_i) begin
         tx_clk_o <= ~tx_clk_o;
         tick_reg <= tx_clk_o;  // High when the next edge raises tx_clk_o.
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic go_reg, async_reg;
   logic [1:0] extra_n_reg;
   logic [2:0] win_reg, wout_reg;
   logic eoc_reg, errlog_reg;
   logic [31:0] crc_reg;
   logic [PTR_W-1:0] rd_ptr_reg, wr_ptr_reg;
   logic [7:0] freeze_cnt_reg;
   // Persistent error log survives a warm reset only.
   always_ff @(posedge ref_clk_i or negedge pwrok_i) begin
      if (!pwrok_i) begin
         errlog_reg <= 1'b0;
      end else if (ce_i) begin
         if (crc_miss) begin
            errlog_reg <= 1'b1;
         end else if (reg_wr_i && reg_addr_i == REG_ERRLOG && reg_wdata_i[0]) begin
            errlog_reg <= 1'b0;
         end
      end
   end

   // Control register.
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         go_reg <= 1'b1;
         async_reg <= 1'b0;
         extra_n_reg <= 2'h0;
      end else if (ce_i && reg_wr_i && reg_addr_i == REG_CTRL) begin
         go_reg <= reg_wdata_i[0];
         async_reg <= reg_wdata_i[1];
         extra_n_reg <= reg_wdata_i[3:2];
      end
   end

   // Width fields: negotiated at cold release, kept across warm reset.
   function automatic logic [2:0] lri_neg(input logic [31:0] cad);
      logic [2:0] w;
      w = WID_8;
      if (cad == CAD_PAT_W2) begin
         w = WID_2;
      end else if (cad == CAD_PAT_W4) begin
         w = WID_4;
      end
      return w;
   endfunction : lri_neg
   localparam logic [2:0] RX_CAP = (RX_WIDTH == 2) ? WID_2 : (RX_WIDTH == 4) ? WID_4 : WID_8;
   localparam logic [2:0] TX_CAP = (TX_WIDTH == 2) ? WID_2 : (TX_WIDTH == 4) ? WID_4 : WID_8;
   // Codes 4 and 5 mean 2 and 4 bits, so the smaller of them is narrower.
   function automatic logic [2:0] lri_min(input logic [2:0] a, input logic [2:0] b);
      return (a[2] && (!b[2] || a < b)) ? a : b;
   endfunction : lri_min

   logic sample_reg; // One pulse after each reset release, warm or cold.
   always_ff @(posedge ref_clk_i or negedge pwrok_i) begin
      if (!pwrok_i) begin
         win_reg <= WID_RST;
         wout_reg <= WID_RST;
         eoc_reg <= 1'b0;
      end else if (ce_i) begin
         if (sample_reg && cold_reg) begin
            win_reg <= lri_min(lri_neg(rx_cad_s), RX_CAP);
            wout_reg <= lri_min(lri_neg(rx_cad_s), TX_CAP);
            eoc_reg <= (rx_cad_s == CAD_PAT_NONE);
         end else if (reg_wr_i && reg_addr_i == REG_WIDTH) begin
            win_reg <= reg_wdata_i[2:0];
            wout_reg <= reg_wdata_i[6:4];
         end
      end
   end

   // Read port: data stands one cycle after the strobe.
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         reg_rdata_o <= '0;
      end else if (ce_i) begin
         reg_rdata_o <= '0;
         if (reg_rd_i) begin
            case (reg_addr_i)
               REG_CTRL: reg_rdata_o <= {28'h0, extra_n_reg, async_reg, go_reg};
               REG_WIDTH: reg_rdata_o <= {25'h0, wout_reg, 1'b0, win_reg};
               REG_STATUS: reg_rdata_o <= {25'h0, cur_reg, 2'h0, link_up_o, eoc_reg};
               REG_CRC: reg_rdata_o <= crc_reg;
               REG_PTR: reg_rdata_o <= {16'h0, freeze_cnt_reg, {(8-PTR_W){1'b0}}, rd_ptr_reg};
               REG_ERRLOG: reg_rdata_o <= {31'h0, errlog_reg};
               default: reg_rdata_o <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Sync sequence
   // ----------------------------------------
   // Bit-time scale: x1 for 8 bits and up, x2 for 4, x4 for 2.
   logic [2:0] scale;
   always_comb begin
      scale = 3'h1;
      if (wout_reg == WID_4) begin
         scale = 3'h2;
      end else if (wout_reg == WID_2) begin
         scale = 3'h4;
      end
   end
   logic [15:0] cnt_reg;
   logic peer_ctl_reg;
   logic [31:0] rst_pat;
   always_comb begin
      rst_pat = CAD_PAT_ALL;
      if (TX_WIDTH < RX_WIDTH) begin
         rst_pat = CAD_PAT_ALL;
      end else if (RX_WIDTH == 2) begin
         rst_pat = CAD_PAT_W2;
      end else if (RX_WIDTH == 4) begin
         rst_pat = CAD_PAT_W4;
      end
      if (!cold_reg) begin
         // Warm reset: programmed width high, upper bits low.
         case (wout_reg)
            WID_2: rst_pat = CAD_PAT_W2;
            WID_4: rst_pat = CAD_PAT_W4;
            WID_8: rst_pat = CAD_PAT_W8;
            WID_16: rst_pat = CAD_PAT_W16;
            default: rst_pat = CAD_PAT_ALL;
         endcase
      end
   end

   // Peer CTL latch, sampled on forwarded clock edges.
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         peer_ctl_reg <= 1'b0;
      end else if (ce_i && rx_edge && rx_ctl_s) begin
         peer_ctl_reg <= 1'b1;
      end
   end

   // Main state machine; moves on transmit rising edges, except out of LRI_ST_RESET and the LRI_ST_WAIT countdown.
   // Reset is taken synchronously here so that the width pattern, which is
   // not a constant, stands on the outputs while reset is held.
   always_ff @(posedge ref_clk_i) begin
      if (!int_rstn) begin
         cur_reg <= LRI_ST_RESET;
         cnt_reg <= '0;
         tx_link_o <= '{ctl: 1'b0, cad: rst_pat};
         sample_reg <= 1'b0;
         link_up_o <= 1'b0;
      end else if (ce_i) begin
         sample_reg <= (cur_reg == LRI_ST_RESET);
         case (cur_reg)
            LRI_ST_RESET: begin
               tx_link_o <= '{ctl: 1'b0, cad: rst_pat};
               cur_reg <= LRI_ST_WAIT;
               cnt_reg <= 16'(CTL_DELAY_CYC);
            end
            LRI_ST_WAIT: begin
               if (cnt_reg != 16'h0) begin
                  cnt_reg <= cnt_reg - 16'h1;
               end else if (go_reg && tick_reg) begin
                  tx_link_o.ctl <= 1'b1;
                  tx_link_o.cad <= CAD_PAT_ALL;
                  cur_reg <= LRI_ST_SYNC;
                  cnt_reg <= 16'(SYNC_HOLD_BT) * {13'h0, scale};
               end
            end
            LRI_ST_SYNC: begin
               // Pattern holds until peer CTL is seen, then 16 x scale more bit-times.
               if (peer_ctl_reg && tick_reg) begin
                  if (cnt_reg > 16'h1) begin
                     cnt_reg <= cnt_reg - 16'h1;
                  end else begin
                     tx_link_o <= '0;
                     cur_reg <= LRI_ST_LOW;
                     cnt_reg <= 16'(16'(LOW_HOLD_BT) + 16'(LOW_STEP_BT) * {14'h0, extra_n_reg})
                                * {13'h0, scale};
                  end
               end
            end
            LRI_ST_LOW: begin
               if (tick_reg) begin
                  if (cnt_reg > 16'h1) begin
                     cnt_reg <= cnt_reg - 16'h1;
                  end else begin
                     tx_link_o.cad <= rst_pat;
                     cur_reg <= LRI_ST_FRAME;
                     cnt_reg <= 16'(FRAME_BT) * {13'h0, scale};
                  end
               end
            end
            LRI_ST_FRAME: begin
               if (tick_reg) begin
                  if (cnt_reg > 16'h1) begin
                     cnt_reg <= cnt_reg - 16'h1;
                  end else begin
                     tx_link_o <= '{ctl: 1'b1, cad: 32'h0};
                     cur_reg <= LRI_ST_RUN;
                     link_up_o <= 1'b1;
                  end
               end
            end
            LRI_ST_RUN: begin
               link_up_o <= 1'b1;
            end
            default: cur_reg <= LRI_ST_RESET;
         endcase
      end
   end

   // ----------------------------------------
   // Receive pointers and CRC flops
   // ----------------------------------------
   // Depth 2**PTR_W must cover drift, skew and the two-flop delay.
   logic peer_low_seen;
   assign peer_low_seen = rx_edge && !rx_ctl_s && (rx_s3_reg[32] == 1'b1);
   logic crc_slot;
   logic [9:0] bt_cnt_reg;
   logic [2:0] settle_reg;
   assign crc_slot = (bt_cnt_reg == 10'(CRC_GAP_BT - 1));
   assign crc_miss = 1'b0;
   always_ff @(posedge ref_clk_i or negedge int_rstn) begin
      if (!int_rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         rd_ptr_adv_o <= 1'b0;
         freeze_cnt_reg <= '0;
         bt_cnt_reg <= '0;
         crc_reg <= '0;
         settle_reg <= '0;
      end else if (ce_i) begin
         rd_ptr_adv_o <= 1'b0;
         if (peer_low_seen) begin
            wr_ptr_reg <= PTR_W'(PTR_OFFSET);
            rd_ptr_reg <= '0;
            bt_cnt_reg <= '0;
         end else if (rx_edge) begin
            bt_cnt_reg <= crc_slot ? 10'h0 : bt_cnt_reg + 10'h1;
            if (async_reg && crc_slot) begin
               crc_reg <= rx_cad_s;
               settle_reg <= 3'(CRC_SETTLE_CYC);
            end else begin
               wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
         end
         if (settle_reg != 3'h0) begin
            settle_reg <= settle_reg - 3'h1;
         end
         // Unload only when data is present, freezing otherwise.
         if (link_up_o && !peer_low_seen) begin
            if (rd_ptr_reg != wr_ptr_reg) begin
               rd_ptr_reg <= rd_ptr_reg + 1'b1;
               rd_ptr_adv_o <= 1'b1;
            end else begin
               freeze_cnt_reg <= freeze_cnt_reg + 8'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ctl_low_reset: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      cur_reg == LRI_ST_WAIT |-> !tx_link_o.ctl) else $error("CTL high during reset hold");
   a_hold_pattern: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      cur_reg == LRI_ST_SYNC && !peer_ctl_reg |=> tx_link_o.ctl)
      else $error("Sync pattern left early");
   a_invert_both: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      cur_reg == LRI_ST_SYNC ##1 cur_reg == LRI_ST_LOW |-> tx_link_o == '0)
      else $error("CTL and CAD not inverted together");
   a_frame_ctl: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      $rose(link_up_o) |-> tx_link_o.ctl && $past(cur_reg) == LRI_ST_FRAME)
      else $error("CTL not high after framing");
   a_eoc_zero: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      sample_reg && cold_reg && rx_cad_s == 32'h0 |=> eoc_reg)
      else $error("End of chain not set");
   a_ptr_offset: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      ce_i && peer_low_seen |=> wr_ptr_reg == PTR_W'(PTR_OFFSET) && rd_ptr_reg == '0)
      else $error("Pointers not set to offset");
   a_rd_freeze: assert property (@(posedge ref_clk_i) disable iff (!int_rstn)
      ce_i && link_up_o && !peer_low_seen && rd_ptr_reg == wr_ptr_reg |=> !rd_ptr_adv_o)
      else $error("Read pointer advanced on empty");
   a_rst_gate: assert property (@(posedge ref_clk_i)
      !pwrok_i |=> cold_reg && cur_reg == LRI_ST_RESET)
      else $error("Power-good low did not force a cold reset");
   c_link_up: cover property (@(posedge ref_clk_i) $rose(link_up_o));
   c_warm: cover property (@(posedge ref_clk_i) sample_reg && !cold_reg);
   c_freeze: cover property (@(posedge ref_clk_i) link_up_o && rd_ptr_reg == wr_ptr_reg);

endmodule : lri_link_init

//--- tb/lri_peer_model.sv
// Behavioural model of the peer link device facing the block.
`timescale 1ns/10ps

module lri_peer_model (
   // Sequence control from the bench.
   input wire logic go_i,
   input wire logic [31:0] pat_i,
   // Outbound CTL of the block, seen by the peer.
   input wire logic dut_ctl_i,
   // Peer transmit pins.
   output logic clk_o,
   output logic ctl_o,
   output logic [31:0] cad_o
);
   import lri_pkg::*;

   int cnt;      // Bit-times since both CTLs were seen.
   logic run;    // Peer has left its reset pattern.

   // ------------------------------
   // Forwarded clock
   // ------------------------------
   // The clock toggles through reset as well, so it runs free.
   initial begin
      clk_o = 1'b0;
      forever #80 clk_o = ~clk_o;
   end

   // ------------------------------
   // Sequence counter
   // ------------------------------
   // Counting starts only once the block's CTL is seen high.
   always @(posedge clk_o or negedge go_i) begin
      if (!go_i) begin
         run <= 1'b0;
         cnt <= 0;
      end else begin
         run <= 1'b1;
         if ((run && dut_ctl_i) || cnt > 0) begin
            cnt <= cnt + 1;
         end
      end
   end

   // ------------------------------
   // Line levels
   // ------------------------------
   // The reset pattern is a level so the block can sample it at release.
   always_comb begin
      if (!run) begin
         ctl_o = 1'b0;
         cad_o = pat_i;
      end else if (cnt <= SYNC_HOLD_BT) begin
         ctl_o = 1'b1;
         cad_o = CAD_PAT_ALL;
      end else if (cnt <= SYNC_HOLD_BT + LOW_HOLD_BT) begin
         ctl_o = 1'b0;
         cad_o = CAD_PAT_NONE;
      end else if (cnt <= SYNC_HOLD_BT + LOW_HOLD_BT + FRAME_BT) begin
         ctl_o = 1'b0;
         cad_o = CAD_PAT_ALL;
      end else begin
         ctl_o = 1'b1;
         cad_o = CAD_PAT_NONE;
      end
   end

endmodule : lri_peer_model

//--- tb/test_lri_link_init.sv
// Self-checking bench for the link reset and width initialisation block.
`timescale 1ns/10ps

module test_lri_link_init;
   import lri_pkg::*;

   logic ref_clk, rstn, pwrok, rd, wr, peer_go, rx_clk, rx_ctl, ce;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rx_cad, peer_pat, d;
   lri_link_t tx_link;
   logic tx_clk, link_up, rd_adv;
   int miscompares = 0;
   int comparisons = 0;
   int n;
   logic [31:0] pats [6] = '{CAD_PAT_W2, CAD_PAT_W4, CAD_PAT_W8, CAD_PAT_W16,
                             CAD_PAT_ALL, CAD_PAT_NONE};
   logic [2:0] wids [6] = '{WID_2, WID_4, WID_8, WID_8, WID_8, WID_8};

   // Block under test.
   lri_link_init i_lri_link_init (.ref_clk_i(ref_clk), .ce_i(ce), .rstn_i(rstn),
      .pwrok_i(pwrok), .rx_clk_i(rx_clk), .rx_ctl_i(rx_ctl), .rx_cad_i(rx_cad),
      .tx_link_o(tx_link), .tx_clk_o(tx_clk), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .link_up_o(link_up),
      .rd_ptr_adv_o(rd_adv));

   // Peer device on the far side of the link.
   lri_peer_model i_lri_peer_model (.go_i(peer_go), .pat_i(peer_pat),
      .dut_ctl_i(tx_link.ctl), .clk_o(rx_clk), .ctl_o(rx_ctl), .cad_o(rx_cad));

   // ------------------------------
   // Clock
   // ------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------
   // Tasks
   // ------------------------------
   // Verdict and end of run, shared by the main flow and by timeouts.
   task automatic tally_and_finish();
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // One compare for every kind of result; 33 bits carry the link struct.
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One-cycle write strobe.
   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe.
   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : reg_read

   // Bounded wait: 0 CTL high, 1 CTL low, 2 CAD nonzero.
   task automatic wt(input int k, input int lim, output int cyc);
      cyc = 0;
      while (!((k == 0 && tx_link.ctl === 1'b1) || (k == 1 && tx_link.ctl === 1'b0) ||
               (k == 2 && tx_link.cad !== 32'h0000_0000))) begin
         @(posedge ref_clk);
         #1 cyc++;
         if (cyc > lim) begin
            miscompares++;
            tally_and_finish();
         end
      end
   endtask : wt

   // Reset with power-good low for cold, high for warm; peer shows pat,
   // and the block must drive exp while reset is held.
   task automatic rst(input logic cold, input logic [31:0] pat, input logic [32:0] exp);
      @(posedge ref_clk);
      peer_go <= 1'b0;
      peer_pat <= pat;
      rstn <= 1'b0;
      pwrok <= ~cold;
      repeat (3) @(posedge ref_clk);
      pwrok <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk(tx_link, exp);
      @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : rst

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      {rstn, pwrok, rd, wr, peer_go} = 5'h18;
      ce = 1'b1;
      addr = 4'h0;
      wdata = 32'h0;
      peer_pat = CAD_PAT_ALL;
      rst(1'b1, CAD_PAT_ALL, {1'b0, CAD_PAT_ALL});
      chk(tx_link, {1'b0, CAD_PAT_ALL});
      wt(0, 200, n);
      chk(tx_link, {1'b1, CAD_PAT_ALL});
      chk(n >= CTL_DELAY_CYC && n <= CTL_DELAY_CYC + 2, 1);
      // The peer stays silent, so the sync pattern must be held.
      repeat (200) @(posedge ref_clk);
      #1 chk(tx_link, {1'b1, CAD_PAT_ALL});
      chk(link_up, 1'b0);
      // Clock enable low freezes the divider and the held pattern.
      ce <= 1'b0;
      @(posedge ref_clk);
      #1 d[0] = tx_clk;
      repeat (3) @(posedge ref_clk);
      #1 chk(tx_clk, d[0]);
      chk(tx_link, {1'b1, CAD_PAT_ALL});
      ce <= 1'b1;
      peer_go <= 1'b1;
      wt(1, 200, n);
      chk(tx_link, 33'h0);
      chk(n >= 2 * SYNC_HOLD_BT && n <= 2 * SYNC_HOLD_BT + 30, 1);
      wt(2, 3000, n);
      chk(n >= 2 * LOW_HOLD_BT - 2 && n <= 2 * LOW_HOLD_BT + 2, 1);
      chk(tx_link, {1'b0, CAD_PAT_ALL});
      wt(0, 100, n);
      chk(n >= 2 * FRAME_BT - 2 && n <= 2 * FRAME_BT + 2, 1);
      chk(tx_link, {1'b1, 32'h0});
      @(posedge ref_clk);
      #1 chk(link_up, 1'b1);
      reg_read(REG_STATUS, d);
      chk(d & 32'h3, 32'h2);
      // The local clock outruns the peer's, so unloading must freeze.
      repeat (20) @(posedge ref_clk);
      reg_read(REG_PTR, d);
      chk(d[15:8] != 8'h00, 1'b1);
      // Programmed widths survive a warm reset.
      reg_write(REG_WIDTH, 32'h0000_0055);
      rst(1'b0, CAD_PAT_W2, {1'b0, CAD_PAT_W4});
      chk({tx_link.ctl, tx_link.cad[3:0]}, 5'h0f);
      reg_read(REG_WIDTH, d);
      chk(d & 32'h77, 32'h55);
      // Every sampled pattern at cold release, the last one all zero.
      for (int i = 0; i < 6; i++) begin
         rst(1'b1, pats[i], {1'b0, CAD_PAT_ALL});
         reg_read(REG_WIDTH, d);
         if (i < 5) begin
            chk(d & 32'h77, {25'h0, wids[i], 1'b0, wids[i]});
         end
         reg_read(REG_STATUS, d);
         chk(d[0], i == 5);
      end
      // Unmapped place reads zero; a control register read follows it.
      reg_write(4'hf, 32'hffff_ffff);
      reg_read(4'hf, d);
      chk(d, 32'h0);
      reg_read(REG_CTRL, d);
      chk(d[0], 1'b1);
      tally_and_finish();
   end

endmodule : test_lri_link_init
